/* bench/pbs_consumer.sv */
// read-side consumer that takes words at once or stalls
module pbs_consumer
(
	input  wire logic clk_in,
	input  wire logic stall_in,
	output logic      rd_ready_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic ready_r = 1'b0;
	// changes only between edges
	always @(negedge clk_in)
		ready_r <= !stall_in;
	assign rd_ready_out = ready_r;
endmodule // pbs_consumer

/* bench/pipelined_burst_sync_sram_tb.sv */
// self-checking bench for the burst sram core
module pipelined_burst_sync_sram_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic              clk_in = 1'b0;
	logic              reset_in = 1'b1;
	logic              order = 1'b0;
	logic              oe_n = 1'b1;
	logic              stall = 1'b0;
	logic              rdy;
	logic [17:0]       addr = 18'h0;
	logic [17:0]       din = 18'h0;
	logic [17:0]       dout;
	logic              oe;
	logic              vld;
	logic              bufrdy;
	// strobes off, chip selected
	pbs_pkg::pbs_ctl_t idle = 10'h3FA;
	pbs_pkg::pbs_ctl_t ctl = 10'h3FA;
	logic [17:0]       ref_mem [int];
	logic [17:0]       exp_q [$];
	int                n_errors = 0;
	int                n_tests = 0;
	int                cycles = 0;

	initial
		forever #2 clk_in = ~clk_in;

	pbs_sram u_dut
	(
		.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr),
		.proc_addr_strobe_n_in(ctl.proc_strobe_n), .ctrl_addr_strobe_n_in(ctl.ctrl_strobe_n),
		.burst_advance_n_in(ctl.advance_n), .write_enable_n_in(ctl.write_enable_n),
		.global_write_n_in(ctl.global_write_n), .byte_write_lo_n_in(ctl.byte_write_n[0]),
		.byte_write_hi_n_in(ctl.byte_write_n[1]),
		.chip_enable_primary_n_in(ctl.ce_primary_n),
		.chip_enable_expand_hi_in(ctl.ce_expand_hi),
		.chip_enable_expand_lo_n_in(ctl.ce_expand_lo_n),
		.burst_order_sel_in(order), .out_enable_n_in(oe_n), .rd_ready_in(rdy),
		.data_io_in(din), .data_io_out(dout), .data_io_oe_out(oe),
		.rd_valid_out(vld), .buf_ready_out(bufrdy)
	);

	pbs_consumer u_cons
	(
		.clk_in(clk_in), .stall_in(stall), .rd_ready_out(rdy)
	);

	task automatic check(input logic [17:0] seen, input logic [17:0] exp, input string what);
		n_tests++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("checks %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic drive(input pbs_pkg::pbs_ctl_t v, input logic [17:0] a, input logic [17:0] d);
		ctl = v;
		addr = a;
		din = d;
		@(negedge clk_in);
	endtask

	// n beats from a; kind follows the write pins, p starts with the processor strobe
	task automatic burst(input int n, input logic p, input logic wen, input logic gwn,
		input logic [1:0] bwn, input logic [17:0] a);
		pbs_pkg::pbs_ctl_t v;
		logic [17:0]       ba;
		logic [17:0]       d;
		logic [17:0]       w;
		logic              wr;
		wr = !gwn || (!wen && bwn != 2'h3);
		oe_n = wr;
		for (int i = 0; i < n; i++)
		begin
			v = idle;
			v.write_enable_n = wen;
			v.global_write_n = gwn;
			v.byte_write_n = bwn;
			v.proc_strobe_n = !(i == 0 && p);
			v.ctrl_strobe_n = !(i == 0 && !p);
			v.advance_n = (i == 0);
			ba = {a[17:2], order ? (a[1:0] ^ 2'(i)) : (a[1:0] + 2'(i))};
			d = 18'($urandom);
			w = ref_mem.exists(int'(ba)) ? ref_mem[int'(ba)] : 18'hX;
			if (!gwn || (!wen && !bwn[0])) w[8:0] = d[8:0];
			if (!gwn || (!wen && !bwn[1])) w[17:9] = d[17:9];
			if (wr)
				ref_mem[int'(ba)] = w;
			else
				exp_q.push_back(w);
			drive(v, ba, d);
		end
	endtask

	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles > 2000)
		begin
			n_errors++;
			final_report();
		end
		else if (!reset_in && vld === 1'b1 && rdy === 1'b1)
		begin
			if (exp_q.size() == 0)
				check(18'h1, 18'h0, "unexpected word");
			else
				check(dout, exp_q.pop_front(), "read word");
			check({17'h0, oe}, {17'h0, !oe_n}, "output enable");
		end
	end

	initial
	begin
		logic [17:0]       a;
		logic [1:0]        bws [3];
		pbs_pkg::pbs_ctl_t v;
		void'($urandom(32'hFD191E10));
		bws = '{2'h2, 2'h1, 2'h0};
		for (int o = 0; o < 2; o++)
		begin
			reset_in = 1'b1;
			order = o[0];
			repeat (2) @(negedge clk_in);
			reset_in = 1'b0;
			a = 18'($urandom);
			burst(4, 1'b0, 1'b1, 1'b0, 2'h3, a);
			burst(4, 1'b0, 1'b1, 1'b1, 2'h3, a);
			for (int k = 0; k < 3; k++)
			begin
				burst(4, 1'b0, 1'b0, 1'b1, bws[k], a);
				burst(4, k == 1, 1'b1, 1'b1, 2'h3, a);
			end
			// write enable without any byte lane reads
			burst(2, 1'b0, 1'b0, 1'b1, 2'h3, a);
			v = idle;
			v.ctrl_strobe_n = 1'b0;
			v.ce_primary_n = 1'b1;
			drive(v, a, 18'h0);
			v = idle;
			v.proc_strobe_n = 1'b0;
			v.ce_primary_n = 1'b1;
			drive(v, a, 18'h0);
			drive(idle, a, 18'h0);
			stall <= 1'b1;
			burst(2, 1'b0, 1'b1, 1'b1, 2'h3, a ^ 18'h2);
			v = idle;
			v.ctrl_strobe_n = 1'b0;
			v.ce_expand_lo_n = 1'b1;
			drive(v, a, 18'h0);
			repeat (3) @(negedge clk_in);
			check({17'h0, bufrdy}, 18'h0, "buffer full");
			stall <= 1'b0;
			repeat (6) @(negedge clk_in);
			check(18'(exp_q.size()), 18'h0, "words left");
		end
		final_report();
	end
endmodule // pipelined_burst_sync_sram_tb

/* hw/pbs_defines.svh */
// constants for the pipelined burst synchronous sram
`ifndef PBS_DEFINES_SVH
`define PBS_DEFINES_SVH

`define PBS_ADDR_W     18
`define PBS_DATA_W     18
`define PBS_LANE_W     9
`define PBS_LANES      2
`define PBS_DEPTH      262144
`define PBS_BEAT_W     2
`define PBS_BUF_CNT_W  2
`define PBS_BUF_DEPTH  2'h2
`define PBS_LANE_LO    0
`define PBS_LANE_HI    1
`define PBS_BEAT_ZERO  2'h0
`define PBS_BEAT_ONE   2'h1

`endif

/* hw/pbs_pkg.sv */
// types shared by the pipelined burst synchronous sram
package pbs_pkg;

	// control pins as captured by the input registers, all active low except ce_expand_hi
	typedef struct packed {
		logic proc_strobe_n;
		logic ctrl_strobe_n;
		logic advance_n;
		logic write_enable_n;
		logic global_write_n;
		logic [1:0] byte_write_n;
		logic ce_primary_n;
		logic ce_expand_hi;
		logic ce_expand_lo_n;
	} pbs_ctl_t;

	// access kind of the current cycle, gray coded along idle-read-write
	typedef enum logic [1:0] {
		PBS_IDLE  = 2'b00,
		PBS_READ  = 2'b01,
		PBS_WRITE = 2'b11
	} pbs_op_t;

endpackage

/* hw/pbs_sram.sv */
// pipelined burst synchronous sram core with two-entry read buffer
`include "pbs_defines.svh"

module pbs_sram
(
	input  wire logic                    clk_in,
	input  wire logic                    reset_in,
	input  wire logic [`PBS_ADDR_W-1:0]  addr_in,
	input  wire logic                    proc_addr_strobe_n_in,
	input  wire logic                    ctrl_addr_strobe_n_in,
	input  wire logic                    burst_advance_n_in,
	input  wire logic                    write_enable_n_in,
	input  wire logic                    global_write_n_in,
	input  wire logic                    byte_write_lo_n_in,
	input  wire logic                    byte_write_hi_n_in,
	input  wire logic                    chip_enable_primary_n_in,
	input  wire logic                    chip_enable_expand_hi_in,
	input  wire logic                    chip_enable_expand_lo_n_in,
	input  wire logic                    burst_order_sel_in,
	input  wire logic                    out_enable_n_in,
	input  wire logic                    rd_ready_in,
	input  wire logic [`PBS_DATA_W-1:0]  data_io_in,
	output logic      [`PBS_DATA_W-1:0]  data_io_out,
	output logic                         data_io_oe_out,
	output logic                         rd_valid_out,
	output logic                         buf_ready_out
);

	// input registers, noninverting
	pbs_pkg::pbs_ctl_t               ctl_r;
	logic [`PBS_ADDR_W-1:0]          addr_r;
	logic [`PBS_DATA_W-1:0]          din_r;

	// burst state
	logic [`PBS_ADDR_W-1:0]          base_r;
	logic [`PBS_BEAT_W-1:0]          beat_r;
	logic                            active_r;

	// storage and read buffer
	logic [`PBS_DATA_W-1:0]          mem [0:`PBS_DEPTH-1];
	logic [`PBS_DATA_W-1:0]          buf_r [0:1];
	logic [`PBS_BUF_CNT_W-1:0]       cnt_r;
	logic [`PBS_BUF_CNT_W-1:0]       cnt_nxt;
	logic                            full_r;
	logic                            valid_r;
	logic                            ready_r;

	// decode of the registered cycle
	wire selected   = !ctl_r.ce_primary_n && ctl_r.ce_expand_hi && !ctl_r.ce_expand_lo_n;
	wire proc_start = !ctl_r.proc_strobe_n && !ctl_r.ce_primary_n;
	wire ctrl_start = !ctl_r.ctrl_strobe_n && !proc_start;
	wire new_start  = proc_start || ctrl_start;
	wire wr_any_lane = !ctl_r.byte_write_n[`PBS_LANE_LO] || !ctl_r.byte_write_n[`PBS_LANE_HI];
	wire wr_cycle   = (!ctl_r.write_enable_n && wr_any_lane) || !ctl_r.global_write_n;
	wire step       = !new_start && !ctl_r.advance_n;

	wire                            cur_active = new_start ? selected : active_r;
	wire [`PBS_ADDR_W-1:0]          cur_base   = new_start ? addr_r : base_r;
	wire [`PBS_BEAT_W-1:0]          beat_inc   = beat_r + `PBS_BEAT_ONE;
	wire [`PBS_BEAT_W-1:0]          cur_beat   = new_start ? `PBS_BEAT_ZERO :
		(step ? beat_inc : beat_r);
	wire [`PBS_BEAT_W-1:0]          base_lo    = cur_base[`PBS_BEAT_W-1:0];
	wire [`PBS_BEAT_W-1:0]          lo_ilv     = base_lo ^ cur_beat;
	wire [`PBS_BEAT_W-1:0]          lo_lin     = base_lo + cur_beat;
	// order select is used live, never captured
	wire [`PBS_BEAT_W-1:0]          cur_lo     = burst_order_sel_in ? lo_ilv : lo_lin;
	wire [`PBS_ADDR_W-1:0]          cur_addr   = {cur_base[`PBS_ADDR_W-1:`PBS_BEAT_W], cur_lo};

	// processor strobe never writes
	wire            write_ok = cur_active && wr_cycle && !proc_start;
	pbs_pkg::pbs_op_t op;
	assign op = !cur_active ? pbs_pkg::PBS_IDLE :
		(write_ok ? pbs_pkg::PBS_WRITE : pbs_pkg::PBS_READ);

	wire [`PBS_DATA_W-1:0] rd_word = mem[cur_addr];
	logic rd_push;
	logic wr_go;
	always_comb
	begin
		rd_push = 1'b0;
		wr_go   = 1'b0;
		unique case (op)
			pbs_pkg::PBS_IDLE:  ;
			pbs_pkg::PBS_READ:  rd_push = !full_r;
			pbs_pkg::PBS_WRITE: wr_go = 1'b1;
			default:            ;
		endcase
	end
	wire rd_pop = rd_ready_in && (cnt_r != `PBS_BUF_CNT_W'h0);

	// per-lane write strobes and merged write word
	wire [`PBS_LANES-1:0]  lane_we;
	wire [`PBS_DATA_W-1:0] wr_word;
	genvar gl;
	generate
		for (gl = 0; gl < `PBS_LANES; gl++)
		begin : g_lane
			// global write overrides byte selects
			assign lane_we[gl] = wr_go && (!ctl_r.global_write_n ||
				(!ctl_r.write_enable_n && !ctl_r.byte_write_n[gl]));
			// an unselected lane keeps its stored bits
			assign wr_word[gl*`PBS_LANE_W +: `PBS_LANE_W] = lane_we[gl] ?
				din_r[gl*`PBS_LANE_W +: `PBS_LANE_W] :
				rd_word[gl*`PBS_LANE_W +: `PBS_LANE_W];
		end
	endgenerate

	// single writer of the array; the write finishes at the next edge
	always_ff @(posedge clk_in)
	begin
		if (wr_go)
			mem[cur_addr] <= wr_word;
	end

	// input capture
	always_ff @(posedge clk_in)
	begin
		addr_r                 <= addr_in;
		din_r                  <= data_io_in;
		ctl_r.proc_strobe_n    <= proc_addr_strobe_n_in;
		ctl_r.ctrl_strobe_n    <= ctrl_addr_strobe_n_in;
		ctl_r.advance_n        <= burst_advance_n_in;
		ctl_r.write_enable_n   <= write_enable_n_in;
		ctl_r.global_write_n   <= global_write_n_in;
		ctl_r.byte_write_n     <= {byte_write_hi_n_in, byte_write_lo_n_in};
		ctl_r.ce_primary_n     <= chip_enable_primary_n_in;
		ctl_r.ce_expand_hi     <= chip_enable_expand_hi_in;
		ctl_r.ce_expand_lo_n   <= chip_enable_expand_lo_n_in;
	end

	// burst counter and base
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			active_r <= 1'b0;
			base_r   <= `PBS_ADDR_W'h0;
			beat_r   <= `PBS_BEAT_ZERO;
		end
		else
		begin
			active_r <= cur_active;
			base_r   <= cur_base;
			beat_r   <= cur_beat;
		end
	end

	// two-entry read buffer; head entry is the output register
	assign cnt_nxt = cnt_r + {1'b0, rd_push} - {1'b0, rd_pop};
	always_ff @(posedge clk_in)
	begin
		if (reset_in)
		begin
			cnt_r   <= `PBS_BUF_CNT_W'h0;
			full_r  <= 1'b0;
			valid_r <= 1'b0;
			ready_r <= 1'b1;
		end
		else
		begin
			cnt_r   <= cnt_nxt;
			full_r  <= (cnt_nxt == `PBS_BUF_DEPTH);
			valid_r <= (cnt_nxt != `PBS_BUF_CNT_W'h0);
			ready_r <= (cnt_nxt != `PBS_BUF_DEPTH);
		end
	end

	wire head_load = rd_push && ((cnt_r == `PBS_BUF_CNT_W'h0) ||
		(cnt_r == `PBS_BUF_CNT_W'h1 && rd_pop));
	always_ff @(posedge clk_in)
	begin
		if (rd_pop)
			buf_r[0] <= head_load ? rd_word : buf_r[1];
		else if (head_load)
			buf_r[0] <= rd_word;
		if (rd_push && !head_load)
			buf_r[1] <= rd_word;
	end

	assign data_io_out   = buf_r[0];
	assign rd_valid_out  = valid_r;
	assign buf_ready_out = ready_r;
	// driver enable follows the enable pin without the clock, only while a read word is valid
	assign data_io_oe_out = !out_enable_n_in && rd_valid_out;

	// checks
	a_read_pipe: assert property (@(posedge clk_in) disable iff (reset_in)
		rd_push && cnt_r == `PBS_BUF_CNT_W'h0 |=> data_io_out == $past(rd_word) && rd_valid_out)
		else $error("read word not in output register one edge later");

	a_proc_no_write: assert property (@(posedge clk_in) disable iff (reset_in)
		proc_start |-> !wr_go)
		else $error("processor strobe caused a write");

	a_proc_ignored: assert property (@(posedge clk_in) disable iff (reset_in)
		ctl_r.ce_primary_n && ctl_r.ctrl_strobe_n |-> cur_active == active_r)
		else $error("processor strobe acted while primary enable negated");

	a_deselect: assert property (@(posedge clk_in) disable iff (reset_in)
		new_start && !selected |-> op == pbs_pkg::PBS_IDLE ##1 !active_r)
		else $error("deselect did not idle the device");

	a_linear_wrap: assert property (@(posedge clk_in) disable iff (reset_in)
		new_start && !burst_order_sel_in ##1 step && !burst_order_sel_in
		|-> cur_addr[1:0] == $past(cur_addr[1:0]) + 2'h1)
		else $error("linear burst did not step modulo four");

	a_ilv_step: assert property (@(posedge clk_in) disable iff (reset_in)
		new_start && burst_order_sel_in ##1 step && burst_order_sel_in
		|-> cur_addr[1:0] == ($past(cur_addr[1:0]) ^ 2'h1))
		else $error("interleaved burst second beat wrong");

	a_hold_beat: assert property (@(posedge clk_in) disable iff (reset_in)
		!new_start && ctl_r.advance_n |-> cur_addr == $past(cur_addr) || $past(reset_in))
		else $error("burst address moved without advance");

	a_lane_lo_only: assert property (@(posedge clk_in) disable iff (reset_in)
		wr_go && ctl_r.global_write_n && ctl_r.byte_write_n[1] |-> !lane_we[1])
		else $error("hi lane written without its byte write");

	a_global_both: assert property (@(posedge clk_in) disable iff (reset_in)
		wr_go && !ctl_r.global_write_n |-> lane_we == 2'h3)
		else $error("global write did not take both lanes");

	a_write_store: assert property (@(posedge clk_in) disable iff (reset_in)
		lane_we == 2'h3 |=> mem[$past(cur_addr)] == $past(din_r))
		else $error("write data not stored after one edge");

	a_buf_bound: assert property (@(posedge clk_in) disable iff (reset_in)
		cnt_r <= `PBS_BUF_DEPTH && (full_r == (cnt_r == `PBS_BUF_DEPTH)))
		else $error("read buffer count out of range");

	a_lane_hi_only: assert property (@(posedge clk_in) disable iff (reset_in)
		wr_go && ctl_r.global_write_n && ctl_r.byte_write_n[0]
		|-> !lane_we[0])
		else $error("lo lane written without its byte write");

	a_bw_both: assert property (@(posedge clk_in) disable iff (reset_in)
		wr_go && !ctl_r.write_enable_n && ctl_r.byte_write_n == 2'h0
		|-> lane_we == 2'h3)
		else $error("both byte writes did not take both lanes");

	a_write_decode: assert property (@(posedge clk_in) disable iff (reset_in)
		op == pbs_pkg::PBS_WRITE
		|-> (!ctl_r.write_enable_n && ctl_r.byte_write_n != 2'h3) || !ctl_r.global_write_n)
		else $error("write without a write condition on the pins");

	a_read_no_write: assert property (@(posedge clk_in) disable iff (reset_in)
		op == pbs_pkg::PBS_READ
		|-> lane_we == 2'h0)
		else $error("read cycle changed the array");

	a_select_start: assert property (@(posedge clk_in) disable iff (reset_in)
		ctrl_start && selected
		|-> op != pbs_pkg::PBS_IDLE)
		else $error("selected controller start did not begin a cycle");

	a_ctrl_abort: assert property (@(posedge clk_in) disable iff (reset_in)
		ctrl_start
		|=> beat_r == `PBS_BEAT_ZERO && base_r == $past(addr_r))
		else $error("controller strobe did not restart the burst");

	a_proc_abort: assert property (@(posedge clk_in) disable iff (reset_in)
		proc_start && selected
		|-> op == pbs_pkg::PBS_READ ##1 beat_r == `PBS_BEAT_ZERO)
		else $error("processor strobe did not start a read");

	a_step_once: assert property (@(posedge clk_in) disable iff (reset_in)
		step
		|=> beat_r == $past(beat_r) + 2'h1)
		else $error("burst counter did not step by one");

	a_lane_lo_write: assert property (@(posedge clk_in) disable iff (reset_in)
		lane_we == 2'h1
		|=> mem[$past(cur_addr)][`PBS_LANE_W-1:0] == $past(din_r[`PBS_LANE_W-1:0]))
		else $error("lo lane write data not stored");

	a_lane_keep: assert property (@(posedge clk_in) disable iff (reset_in)
		lane_we == 2'h1
		|=> mem[$past(cur_addr)][`PBS_DATA_W-1:`PBS_LANE_W] ==
			$past(rd_word[`PBS_DATA_W-1:`PBS_LANE_W]))
		else $error("hi lane changed by a lo lane write");

	a_buf_hold: assert property (@(posedge clk_in) disable iff (reset_in)
		rd_valid_out && !rd_ready_in
		|=> $stable(data_io_out) && rd_valid_out)
		else $error("waiting read word changed or vanished");

	a_oe_float: assert property (@(posedge clk_in) disable iff (reset_in)
		out_enable_n_in
		|-> !data_io_oe_out)
		else $error("data driven while output enable high");

	a_flag_match: assert property (@(posedge clk_in) disable iff (reset_in)
		rd_valid_out == (cnt_r != `PBS_BUF_CNT_W'h0)
		&& buf_ready_out == !full_r)
		else $error("buffer flags disagree with count");

	a_addr_capture: assert property (@(posedge clk_in) disable iff (reset_in)
		addr_r == $past(addr_in)
		&& din_r == $past(data_io_in))
		else $error("address or data not captured at the edge");

	a_ctl_capture: assert property (@(posedge clk_in) disable iff (reset_in)
		ctl_r.advance_n == $past(burst_advance_n_in)
		&& ctl_r.byte_write_n == $past({byte_write_hi_n_in, byte_write_lo_n_in}))
		else $error("controls not captured at the edge");

	a_base_hold: assert property (@(posedge clk_in) disable iff (reset_in)
		!new_start
		|=> base_r == $past(base_r))
		else $error("burst base changed without a strobe");

	c_burst_read: cover property (@(posedge clk_in) disable iff (reset_in)
		new_start && op == pbs_pkg::PBS_READ ##1 step [*3]);
	c_burst_write: cover property (@(posedge clk_in) disable iff (reset_in)
		ctrl_start && op == pbs_pkg::PBS_WRITE ##1 step && wr_go);
	c_buf_full: cover property (@(posedge clk_in) disable iff (reset_in)
		full_r && !rd_ready_in);
	c_abort: cover property (@(posedge clk_in) disable iff (reset_in)
		step ##1 new_start && selected);
	c_ilv_burst: cover property (@(posedge clk_in) disable iff (reset_in)
		new_start && burst_order_sel_in ##1 step ##1 step);

endmodule // pbs_sram
